// ==== verilog/performance_monitor_pkg.sv ====
`default_nettype none
package performance_monitor_pkg;

    ////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned IDX_W    = 14;

    ////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] TX_SLIP_IDX    = 14'h090f;
    localparam logic [IDX_W-1:0] ZV_HIGH_IDX    = 14'h0910;
    localparam logic [IDX_W-1:0] ZV_LOW_IDX     = 14'h0911;
    localparam logic [IDX_W-1:0] FCS2_IDX       = 14'h091c;
    localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 14'h0920;
    localparam logic [IDX_W-1:0] IRQ_MASK_IDX   = 14'h0921;

    ////////////////////////////////////////////////////////////////////
    // counter widths and values after reset
    localparam int unsigned SLIP_W      = 8;
    localparam int unsigned ZV_W        = 16;
    localparam int unsigned FCS_W       = 8;
    localparam logic [7:0]  CNT8_RESET  = 8'h00;
    localparam logic [15:0] CNT16_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////
    // interrupt status and mask layout
    localparam int unsigned EV_N         = 3;
    localparam int unsigned EV_TX_SLIP   = 0;
    localparam int unsigned EV_ZERO_VIOL = 1;
    localparam int unsigned EV_FCS2      = 2;
    localparam logic [2:0]  IRQ_RESET    = 3'h0;

    ////////////////////////////////////////////////////////////////////
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic tx_slip_repeat;
        logic tx_slip_drop;
        logic zero_violation_events;
        logic link_ctrl2_checksum_errors;
    } performance_monitor_events_t;

endpackage : performance_monitor_pkg
`default_nettype wire

// ==== verilog/sat_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
    parameter int unsigned W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic         inc,
    input  wire logic         clr,
    input  wire logic         sub_en,
    input  wire logic [W-1:0] sub_val,
    output var  logic [W-1:0] count
);

    logic [W-1:0] base;
    logic [W-1:0] count_next;

    // clearing read first, then the event of the same cycle on top
    assign base = clr    ? '0 :
                  sub_en ? count - sub_val :
                  count; // R3

    assign count_next = (inc && base != '1) ? base + 1'b1 : base; // R9

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (ce) begin
            count <= count_next;
        end
    end

endmodule : sat_counter
`default_nettype wire

// ==== verilog/performance_monitor_error_counters.sv ====
// Behaviour
// R1: an 8-bit transmit slip counter rises by one per transmit slip.
// R2: a slip is a frame repeated or dropped by the transmit slip buffer.
// R3: each counter holds events since last read; a read clears the 8-bit counters, R7 the 16-bit one.
// R4: a 16-bit counter rises once per excessive-zero violation.
// R5: the violation count reads as an upper byte and a lower byte.
// R6: software reads the upper byte before the lower byte.
// R7: only an upper read then a lower read clears the 16-bit counter.
// R8: an 8-bit counter counts checksum errors of the second link controller.
// R9: counters stop at all ones and keep an event met by a clearing read.
`timescale 1ns/1ps
`default_nettype none
module performance_monitor_error_counters (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    input  wire performance_monitor_pkg::performance_monitor_events_t   events,
    input  wire logic [performance_monitor_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                     awvalid,
    output var  logic                     awready,
    input  wire logic [performance_monitor_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output var  logic                     wready,
    output var  logic [1:0]               bresp,
    output var  logic                     bvalid,
    input  wire logic                     bready,
    input  wire logic [performance_monitor_pkg::ADDR_W-1:0] araddr,
    input  wire logic                     arvalid,
    output var  logic                     arready,
    output var  logic [performance_monitor_pkg::DATA_W-1:0] rdata,
    output var  logic [1:0]               rresp,
    output var  logic                     rvalid,
    input  wire logic                     rready,
    output var  logic                     irq
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic                          aw_got_reg;
    logic                          aw_got_next;
    logic                          w_got_reg;
    logic                          w_got_next;
    logic [performance_monitor_pkg::IDX_W-1:0]    w_idx_reg;
    logic [performance_monitor_pkg::EV_N-1:0]     wdata_reg;
    logic                          wstrb0_reg;

    logic                          aw_hs;
    logic                          w_hs;
    logic                          ar_hs;
    logic                          do_write;

    logic                          bvalid_next;
    logic [1:0]                    bresp_next;
    logic                          rvalid_next;
    logic [performance_monitor_pkg::DATA_W-1:0]   rdata_next;
    logic [1:0]                    rresp_next;

    logic [performance_monitor_pkg::IDX_W-1:0]    ar_idx;
    logic                          ar_slip;
    logic                          ar_zvh;
    logic                          ar_zvl;
    logic                          ar_fcs;
    logic                          ar_stat;
    logic                          ar_mask;
    logic                          ar_hit;

    logic                          wr_stat;
    logic                          wr_mask;
    logic                          wr_hit;

    logic [performance_monitor_pkg::SLIP_W-1:0]   slip_cnt;
    logic [performance_monitor_pkg::ZV_W-1:0]     zv_cnt;
    logic [performance_monitor_pkg::FCS_W-1:0]    fcs_cnt;

    logic [performance_monitor_pkg::ZV_W-1:0]     zv_snap_reg;
    logic                          zv_armed_reg;
    logic                          zv_armed_next;
    logic                          zv_clear;
    logic [7:0]                    zv_low_byte;

    logic                          slip_event;
    logic                          slip_clear;
    logic                          fcs_clear;

    logic [performance_monitor_pkg::EV_N-1:0]     ev_vec;
    logic [performance_monitor_pkg::EV_N-1:0]     status_reg;
    logic [performance_monitor_pkg::EV_N-1:0]     status_next;
    logic [performance_monitor_pkg::EV_N-1:0]     w1c_bits;
    logic [performance_monitor_pkg::EV_N-1:0]     mask_reg;
    logic [performance_monitor_pkg::EV_N-1:0]     mask_next;

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    assign aw_hs = awvalid && awready;
    assign w_hs  = wvalid && wready;

    // the write happens once both halves are held and no answer waits
    assign do_write = aw_got_reg && w_got_reg && !bvalid;

    assign aw_got_next = aw_got_reg ? !do_write : aw_hs;
    assign w_got_next  = w_got_reg  ? !do_write : w_hs;

    assign wr_stat = w_idx_reg == performance_monitor_pkg::IRQ_STATUS_IDX;
    assign wr_mask = w_idx_reg == performance_monitor_pkg::IRQ_MASK_IDX;

    // counters are mapped but read only: writes to them are ignored
    assign wr_hit = wr_stat || wr_mask ||
                    w_idx_reg == performance_monitor_pkg::TX_SLIP_IDX ||
                    w_idx_reg == performance_monitor_pkg::ZV_HIGH_IDX ||
                    w_idx_reg == performance_monitor_pkg::ZV_LOW_IDX  ||
                    w_idx_reg == performance_monitor_pkg::FCS2_IDX;

    assign bvalid_next = do_write || (bvalid && !bready);
    assign bresp_next  = do_write ?
                         (wr_hit ? performance_monitor_pkg::RESP_OKAY
                                 : performance_monitor_pkg::RESP_SLVERR) :
                         bresp;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            awready    <= 1'b0;
            w_got_reg  <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= performance_monitor_pkg::RESP_OKAY;
        end else if (ce) begin
            aw_got_reg <= aw_got_next;
            awready    <= !aw_got_next;
            w_got_reg  <= w_got_next;
            wready     <= !w_got_next;
            bvalid     <= bvalid_next;
            bresp      <= bresp_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_idx_reg  <= '0;
            wdata_reg  <= '0;
            wstrb0_reg <= 1'b0;
        end else if (ce) begin
            if (aw_hs) begin
                w_idx_reg <= awaddr[performance_monitor_pkg::ADDR_W-1:2];
            end
            if (w_hs) begin
                wdata_reg  <= wdata[performance_monitor_pkg::EV_N-1:0];
                wstrb0_reg <= wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, answer one cycle after taking

    assign ar_hs  = arvalid && arready;
    assign ar_idx = araddr[performance_monitor_pkg::ADDR_W-1:2];

    assign ar_slip = ar_idx == performance_monitor_pkg::TX_SLIP_IDX;
    assign ar_zvh  = ar_idx == performance_monitor_pkg::ZV_HIGH_IDX;
    assign ar_zvl  = ar_idx == performance_monitor_pkg::ZV_LOW_IDX;
    assign ar_fcs  = ar_idx == performance_monitor_pkg::FCS2_IDX;
    assign ar_stat = ar_idx == performance_monitor_pkg::IRQ_STATUS_IDX;
    assign ar_mask = ar_idx == performance_monitor_pkg::IRQ_MASK_IDX;
    assign ar_hit  = ar_slip || ar_zvh || ar_zvl ||
                     ar_fcs || ar_stat || ar_mask;

    // lower byte comes from the snapshot once the upper byte was read
    assign zv_low_byte = zv_armed_reg ? zv_snap_reg[7:0]
                                      : zv_cnt[7:0]; // R6

    assign rdata_next =
        !ar_hs  ? rdata :
        ar_slip ? {24'h000000, slip_cnt} :
        ar_zvh  ? {24'h000000, zv_cnt[15:8]} : // R5
        ar_zvl  ? {24'h000000, zv_low_byte} : // R5
        ar_fcs  ? {24'h000000, fcs_cnt} :
        ar_stat ? {29'h0, status_reg} :
        ar_mask ? {29'h0, mask_reg} :
        32'h00000000;

    assign rresp_next = !ar_hs ? rresp :
                        ar_hit ? performance_monitor_pkg::RESP_OKAY
                               : performance_monitor_pkg::RESP_SLVERR;

    assign rvalid_next = ar_hs || (rvalid && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= performance_monitor_pkg::RESP_OKAY;
        end else if (ce) begin
            arready <= !rvalid_next;
            rvalid  <= rvalid_next;
            rdata   <= rdata_next;
            rresp   <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit slip counter

    // a repeated or a dropped frame is one slip
    assign slip_event = events.tx_slip_repeat ||
                        events.tx_slip_drop; // R2

    assign slip_clear = ar_hs && ar_slip; // R3

    sat_counter #(
        .W       (performance_monitor_pkg::SLIP_W)
    ) u_slip_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .inc     (slip_event), // R1
        .clr     (slip_clear),
        .sub_en  (1'b0),
        .sub_val (performance_monitor_pkg::CNT8_RESET),
        .count   (slip_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // excessive-zero violation counter, 16 bits

    // the upper read snapshots the count; the lower read then removes
    // exactly the snapshot, so events after the upper read survive
    assign zv_clear = ar_hs && ar_zvl && zv_armed_reg; // R7

    assign zv_armed_next = (ar_hs && ar_zvh) ? 1'b1 :
                           (ar_hs && ar_zvl) ? 1'b0 :
                           zv_armed_reg; // R7

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zv_snap_reg  <= performance_monitor_pkg::CNT16_RESET;
            zv_armed_reg <= 1'b0;
        end else if (ce) begin
            zv_armed_reg <= zv_armed_next;
            if (ar_hs && ar_zvh) begin
                zv_snap_reg <= zv_cnt; // R6
            end
        end
    end

    sat_counter #(
        .W       (performance_monitor_pkg::ZV_W)
    ) u_zv_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .inc     (events.zero_violation_events), // R4
        .clr     (1'b0),
        .sub_en  (zv_clear), // R3
        .sub_val (zv_snap_reg),
        .count   (zv_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // second link controller checksum error counter

    assign fcs_clear = ar_hs && ar_fcs; // R3

    sat_counter #(
        .W       (performance_monitor_pkg::FCS_W)
    ) u_fcs_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .inc     (events.link_ctrl2_checksum_errors), // R8
        .clr     (fcs_clear),
        .sub_en  (1'b0),
        .sub_val (performance_monitor_pkg::CNT8_RESET),
        .count   (fcs_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    assign ev_vec[performance_monitor_pkg::EV_TX_SLIP]   = slip_event;
    assign ev_vec[performance_monitor_pkg::EV_ZERO_VIOL] = events.zero_violation_events;
    assign ev_vec[performance_monitor_pkg::EV_FCS2]      =
        events.link_ctrl2_checksum_errors;

    assign w1c_bits = (do_write && wr_stat && wstrb0_reg) ?
                      wdata_reg : '0;

    // a new event wins over a write-one-to-clear in the same cycle
    assign status_next = (status_reg & ~w1c_bits) | ev_vec;

    assign mask_next = (do_write && wr_mask && wstrb0_reg) ?
                       wdata_reg : mask_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= performance_monitor_pkg::IRQ_RESET;
            mask_reg   <= performance_monitor_pkg::IRQ_RESET;
            irq        <= 1'b0;
        end else if (ce) begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            irq        <= |(status_next & mask_next);
        end
    end

endmodule : performance_monitor_error_counters
`default_nettype wire

// ==== dv/performance_monitor_error_counters_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module performance_monitor_error_counters_monitor (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   ce,
    input wire performance_monitor_pkg::performance_monitor_events_t events,
    input wire logic                   awvalid,
    input wire logic                   awready,
    input wire logic                   wvalid,
    input wire logic                   wready,
    input wire logic [1:0]             bresp,
    input wire logic                   bvalid,
    input wire logic                   bready,
    input wire logic [15:0]            araddr,
    input wire logic                   arvalid,
    input wire logic                   arready,
    input wire logic [31:0]            rdata,
    input wire logic [1:0]             rresp,
    input wire logic                   rvalid,
    input wire logic                   rready,
    input wire logic                   irq
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        arvalid && arready && ce;
    endsequence
    sequence wr_taken;
        awvalid && awready && wvalid && wready && ce;
    endsequence
    ////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (rd_taken |=> rvalid)
        else $error("read not answered next cycle");
    read_hold_a: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data changed before taken");
    read_block_a: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
    byte_width_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("register wider than one byte");
    err_data_a: assert property (rvalid && rresp == performance_monitor_pkg::RESP_SLVERR
        |-> rdata == 32'h0)
        else $error("error read returned data");
    slip_okay_a: assert property (rd_taken ##0
        araddr[15:2] == performance_monitor_pkg::TX_SLIP_IDX |=> rresp == performance_monitor_pkg::RESP_OKAY)
        else $error("slip counter read refused");
    write_answer_a: assert property (wr_taken |-> ##[1:3] bvalid)
        else $error("write not answered");
    write_hold_a: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp))
        else $error("write response dropped");
    irq_cause_a: assert property ($rose(irq) |->
        $past(events) != 4'h0 || bvalid)
        else $error("interrupt without cause");
endmodule : performance_monitor_error_counters_monitor
bind performance_monitor_error_counters performance_monitor_error_counters_monitor u_mon (.aclk(aclk),
    .aresetn(aresetn), .ce(ce), .events(events), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
`default_nettype wire

// ==== dv/performance_monitor_error_counters_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module performance_monitor_error_counters_tb_top;
    logic                   aclk, aresetn, ce, awvalid, wvalid, bready;
    logic                   arvalid, rready, awready, wready, bvalid;
    logic                   arready, rvalid, irq;
    logic [1:0]             bresp, rresp;
    logic [3:0]             wstrb;
    logic [15:0]            awaddr, araddr;
    logic [31:0]            wdata, rdata;
    performance_monitor_pkg::performance_monitor_events_t events;
    int                     err_total, comparisons;
    localparam logic [1:0] OK = performance_monitor_pkg::RESP_OKAY;
    localparam logic [1:0] BAD = performance_monitor_pkg::RESP_SLVERR;
    localparam logic [13:0] TX = performance_monitor_pkg::TX_SLIP_IDX;
    localparam logic [13:0] HI = performance_monitor_pkg::ZV_HIGH_IDX;
    localparam logic [13:0] LO = performance_monitor_pkg::ZV_LOW_IDX;
    localparam logic [13:0] FC = performance_monitor_pkg::FCS2_IDX;
    localparam logic [13:0] ST = performance_monitor_pkg::IRQ_STATUS_IDX;
    localparam logic [13:0] MK = performance_monitor_pkg::IRQ_MASK_IDX;
    logic [13:0] regs [6] = '{TX, HI, LO, FC, ST, MK};

    performance_monitor_error_counters dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .events(events), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hung(input int n);
        if (n >= 40) begin
            err_total++;
            tally_and_finish;
        end
    endtask : hung

    task automatic wr(input logic [13:0] i, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        hung(n);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rc(input logic [13:0] i, input logic [31:0] e,
                      input logic [1:0] er, input string nm);
        int n;
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        hung(n);
        chk(nm, rdata, e);
        chk({nm, " resp"}, {30'h0, rresp}, {30'h0, er});
    endtask : rc

    task automatic pulse(input logic [3:0] e, input int n);
        repeat (n) begin
            @(posedge aclk);
            events <= e;
            @(posedge aclk);
            events <= 4'h0;
        end
    endtask : pulse

    task automatic irq_is(input logic e);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask : irq_is
    ////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        ce = 1'b1;
        events = 4'h0;
        wstrb = 4'hf;
        {awaddr, araddr, wdata} = 64'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 6; k++) rc(regs[k], 32'h0, OK, "reset");
        pulse(4'h8, 3);
        pulse(4'h4, 2);
        pulse(4'hc, 1);
        rc(TX, 32'h6, OK, "slip");
        rc(TX, 32'h0, OK, "slip clr");
        pulse(4'h1, 5);
        rc(FC, 32'h5, OK, "fcs");
        rc(FC, 32'h0, OK, "fcs clr");
        pulse(4'h1, 2);
        wr(FC, 32'hff, OK);
        rc(FC, 32'h2, OK, "fcs kept");
        @(posedge aclk);
        ce <= 1'b0;
        pulse(4'h1, 3);
        @(posedge aclk);
        ce <= 1'b1;
        rc(FC, 32'h0, OK, "fcs frozen");
        pulse(4'h8, 300);
        rc(TX, 32'hff, OK, "slip sat");
        pulse(4'h2, 291);
        rc(LO, 32'h23, OK, "zv lo alone");
        rc(LO, 32'h23, OK, "zv lo again");
        rc(HI, 32'h01, OK, "zv hi");
        pulse(4'h2, 1);
        rc(LO, 32'h23, OK, "zv lo snap");
        rc(HI, 32'h0, OK, "zv hi left");
        rc(LO, 32'h1, OK, "zv lo left");
        rc(HI, 32'h0, OK, "zv hi clr");
        rc(LO, 32'h0, OK, "zv lo clr");
        irq_is(1'b0);
        rc(ST, 32'h7, OK, "status");
        wr(MK, 32'h4, OK);
        irq_is(1'b1);
        wr(ST, 32'h4, OK);
        irq_is(1'b0);
        rc(ST, 32'h3, OK, "status w1c");
        pulse(4'h1, 1);
        irq_is(1'b1);
        wstrb <= 4'he;
        wr(ST, 32'h7, OK);
        wstrb <= 4'hf;
        irq_is(1'b1);
        wr(ST, 32'h7, OK);
        irq_is(1'b0);
        rc(MK, 32'h4, OK, "mask");
        rc(14'h0912, 32'h0, BAD, "unmapped");
        wr(14'h0001, 32'h1, BAD);
        tally_and_finish;
    end
endmodule : performance_monitor_error_counters_tb_top
`default_nettype wire
